// [hdl/aoed_pkg.sv]
// Package for the axis operation error detector
package aoed_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NAX = 4;
  localparam int PW  = 32;

  // ------------------------------------------------------------
  // Error codes
  // ------------------------------------------------------------
  localparam logic [31:0] EC_NONE      = 32'h0000_0000;
  localparam logic [31:0] EC_NOT_READY = 32'h0000_3000;
  localparam logic [31:0] EC_SVOFF_RUN = 32'h0000_3001;
  localparam logic [31:0] EC_MAIN_OFF  = 32'h0000_3005;
  localparam logic [31:0] EC_LIM_PLUS  = 32'h0000_3010;
  localparam logic [31:0] EC_LIM_MINUS = 32'h0000_3011;
  localparam logic [31:0] EC_LIM_BOTH  = 32'h0000_3012;
  localparam logic [31:0] EC_SOFT_PLUS = 32'h0000_3020;
  localparam logic [31:0] EC_SOFT_MIN  = 32'h0000_3021;
  localparam logic [31:0] EC_SPD_BASE  = 32'h0000_3025;
  localparam logic [31:0] EC_AXIS_OP   = 32'h0000_3030;
  localparam logic [31:0] EC_ABN_END   = 32'h0000_3031;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_IRQST  = 8'h08;
  localparam logic [7:0] OFS_IRQMSK = 8'h0C;
  localparam logic [7:0] OFS_SLHI   = 8'h10;
  localparam logic [7:0] OFS_SLLO   = 8'h14;
  localparam logic [7:0] OFS_CODE0  = 8'h20;
  localparam int CTRL_SLEN_BIT = 0;
  localparam int CTRL_WARN_BIT = 1;
  localparam int CTRL_CLR_LSB  = 8;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_SLHI = 32'h7FFF_FFFF;
  localparam logic [31:0] RST_SLLO = 32'h8000_0000;

  // Per-axis inputs from the motion core and amplifier
  typedef struct packed {
    logic            start_req;
    logic            servo_on_req;
    logic            servo_lock;
    logic            main_pwr;
    logic            busy;
    logic            lim_plus;
    logic            lim_minus;
    logic signed [PW-1:0] position;
    logic            spd_ovf_valid;
    logic [1:0]      spd_ovf_kind;
    logic            op_fault;
    logic            op_abnormal;
    logic            amp_warning;
  } aoed_axis_in_t;

  typedef enum logic [1:0] {
    AX_IDLE = 2'b00,
    AX_RUN  = 2'b01,
    AX_ERR  = 2'b11
  } aoed_state_t;

endpackage : aoed_pkg

// [hdl/aoed_top.sv]
// Axis operation error detector with AHB-Lite register slave
// Functional notes
// - Start without servo lock refused, code 3000
// - Servo lost while moving gives 3001
// - Servo-on with main power off gives 3005
// - Plus limit active gives 3010
// - Minus limit active gives 3011
// - Both limits active gives 3012 instead
// - Above upper soft limit gives 3020
// - Below lower soft limit gives 3021
// - Speed overflow aborts, gives 3025-3027
// - Operation fault or amp warning gives 3030
// - Abnormal operation end gives 3031
// - Detected only while running, except 3000 and 3005 which are detected in idle
`timescale 1ns/1ns
`default_nettype none
module aoed_top
  import aoed_pkg::*;
(
  input  wire logic                           CLK,
  input  wire logic                           RSTN,
  input  wire logic                           HSEL,
  input  wire logic [31:0]                    HADDR,
  input  wire logic [1:0]                     HTRANS,
  input  wire logic                           HWRITE,
  input  wire logic [2:0]                     HSIZE,
  input  wire logic [31:0]                    HWDATA,
  input  wire logic                           HREADY,
  output logic      [31:0]                    HRDATA,
  output logic                                HREADYOUT,
  output logic                                HRESP,
  input  wire aoed_pkg::aoed_axis_in_t [aoed_pkg::NAX-1:0] AXIS_IN,
  output logic      [aoed_pkg::NAX-1:0]       AXIS_RUN,
  output logic      [aoed_pkg::NAX-1:0]       AXIS_ERR,
  output logic                                IRQ
);
  import aoed_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers for limit inputs
  // ------------------------------------------------------------
  logic [NAX-1:0] lp1_q, lp2_q, lp3_q, lm1_q, lm2_q, lm3_q;
  logic [NAX-1:0] lp_q, lm_q, lp_d, lm_d;

  always_comb begin
    lp_d = lp_q;
    lm_d = lm_q;
    for (int i = 0; i < NAX; i++) begin
      // Change accepted once stages two and three agree
      if (lp2_q[i] == lp3_q[i]) lp_d[i] = lp3_q[i];
      if (lm2_q[i] == lm3_q[i]) lm_d[i] = lm3_q[i];
    end
  end

  always_ff @(posedge CLK) begin
    for (int i = 0; i < NAX; i++) begin
      lp1_q[i] <= AXIS_IN[i].lim_plus;
      lm1_q[i] <= AXIS_IN[i].lim_minus;
    end
    lp2_q <= lp1_q;
    lm2_q <= lm1_q;
    lp3_q <= lp2_q;
    lm3_q <= lm2_q;
    if (!RSTN) begin
      lp_q <= '0;
      lm_q <= '0;
    end else begin
      lp_q <= lp_d;
      lm_q <= lm_d;
    end
  end

  // ------------------------------------------------------------
  // Register file state
  // ------------------------------------------------------------
  logic [31:0]    ctrl_q, ctrl_d;
  logic [31:0]    slhi_q, slhi_d, sllo_q, sllo_d;
  logic [NAX-1:0] irqst_q, irqst_d, irqmsk_q, irqmsk_d;
  logic [NAX-1:0] clr_req;

  // ------------------------------------------------------------
  // Per-axis error detection
  // ------------------------------------------------------------
  aoed_state_t    st_q [NAX];
  aoed_state_t    st_d [NAX];
  logic [31:0]    code_q [NAX];
  logic [31:0]    code_d [NAX];
  logic [NAX-1:0] svon_q, svon_d, evt;

  // ------------------------------------------------------------
  // Fault priority
  // ------------------------------------------------------------
  // Fixed priority: the first fault seen is latched and kept
  function automatic logic [31:0] first_fault(input aoed_axis_in_t a,
                                              input logic lp, input logic lm,
                                              input logic slen, input logic warn,
                                              input logic signed [PW-1:0] hi,
                                              input logic signed [PW-1:0] lo);
    logic [31:0] c;
    c = EC_NONE;
    if (lp && lm) c = EC_LIM_BOTH;
    else if (lp) c = EC_LIM_PLUS;
    else if (lm) c = EC_LIM_MINUS;
    else if (!a.servo_lock) c = EC_SVOFF_RUN;
    else if (slen && a.position > hi) c = EC_SOFT_PLUS;
    else if (slen && a.position < lo) c = EC_SOFT_MIN;
    else if (a.spd_ovf_valid && a.spd_ovf_kind != 2'b11)
      c = EC_SPD_BASE + {30'h0000_0000, a.spd_ovf_kind};
    else if (a.op_fault || (warn && a.amp_warning)) c = EC_AXIS_OP;
    else if (a.op_abnormal) c = EC_ABN_END;
    return c;
  endfunction : first_fault

  always_comb begin
    evt    = '0;
    svon_d = svon_q;
    for (int i = 0; i < NAX; i++) begin
      logic [31:0] f;
      f          = EC_NONE;
      st_d[i]    = st_q[i];
      code_d[i]  = code_q[i];
      svon_d[i]  = AXIS_IN[i].servo_on_req;
      unique case (st_q[i])
        AX_IDLE: begin
          if (AXIS_IN[i].servo_on_req && !svon_q[i] && !AXIS_IN[i].main_pwr) begin
            code_d[i] = EC_MAIN_OFF;
            st_d[i]   = AX_ERR;
            evt[i]    = 1'b1;
          end else if (AXIS_IN[i].start_req) begin
            if (!AXIS_IN[i].servo_lock) begin
              code_d[i] = EC_NOT_READY;
              st_d[i]   = AX_ERR;
              evt[i]    = 1'b1;
            end else begin
              st_d[i] = AX_RUN;
            end
          end
        end
        AX_RUN: begin
          // Checks only armed while an operation runs
          f = first_fault(AXIS_IN[i], lp_q[i], lm_q[i],
                          ctrl_q[CTRL_SLEN_BIT], ctrl_q[CTRL_WARN_BIT],
                          slhi_q, sllo_q);
          if (f != EC_NONE) begin
            code_d[i] = f;
            st_d[i]   = AX_ERR;
            evt[i]    = 1'b1;
          end else if (!AXIS_IN[i].busy) begin
            st_d[i] = AX_IDLE;
          end
        end
        AX_ERR: begin
          // Error reset touches this axis alone
          if (clr_req[i]) begin
            code_d[i] = EC_NONE;
            st_d[i]   = AX_IDLE;
          end
        end
        default: st_d[i] = AX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      svon_q <= '0;
      for (int i = 0; i < NAX; i++) begin
        st_q[i]   <= AX_IDLE;
        code_q[i] <= EC_NONE;
      end
    end else begin
      svon_q <= svon_d;
      for (int i = 0; i < NAX; i++) begin
        st_q[i]   <= st_d[i];
        code_q[i] <= code_d[i];
      end
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  logic        ph_q, ph_d, wr_q, wr_d;
  logic [7:0]  ad_q, ad_d;
  logic [31:0] rdata_q, rdata_d;
  logic        rd_st;

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == OFS_CTRL) r = ctrl_q;
    else if (a == OFS_STAT) begin
      for (int i = 0; i < NAX; i++) begin
        r[2*i +: 2] = st_q[i];
      end
    end
    else if (a == OFS_IRQST) r[NAX-1:0] = irqst_q;
    else if (a == OFS_IRQMSK) r[NAX-1:0] = irqmsk_q;
    else if (a == OFS_SLHI) r = slhi_q;
    else if (a == OFS_SLLO) r = sllo_q;
    else begin
      for (int i = 0; i < NAX; i++) begin
        if (a == OFS_CODE0 + 8'(4*i)) r = code_q[i];
      end
    end
    return r;
  endfunction : read_mux

  always_comb begin
    ph_d    = HSEL && HREADY && HTRANS[1];
    wr_d    = HWRITE;
    ad_d    = {HADDR[7:2], 2'b00};
    rdata_d = read_mux(ad_d);
    ctrl_d  = ctrl_q;
    slhi_d  = slhi_q;
    sllo_d  = sllo_q;
    irqmsk_d = irqmsk_q;
    clr_req = '0;
    rd_st   = ph_d && !HWRITE && (ad_d == OFS_IRQST);
    if (ph_q && wr_q) begin
      if (ad_q == OFS_CTRL) begin
        ctrl_d  = HWDATA;
        ctrl_d[CTRL_CLR_LSB +: NAX] = '0;
        clr_req = HWDATA[CTRL_CLR_LSB +: NAX];
      end
      if (ad_q == OFS_SLHI) slhi_d = HWDATA;
      if (ad_q == OFS_SLLO) sllo_d = HWDATA;
      if (ad_q == OFS_IRQMSK) irqmsk_d = HWDATA[NAX-1:0];
    end
    // Read clears, but a new event in that cycle survives
    irqst_d = (rd_st ? '0 : irqst_q) | evt;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ph_q     <= 1'b0;
      wr_q     <= 1'b0;
      ad_q     <= 8'h00;
      rdata_q  <= 32'h0000_0000;
      ctrl_q   <= RST_CTRL;
      slhi_q   <= RST_SLHI;
      sllo_q   <= RST_SLLO;
      irqst_q  <= '0;
      irqmsk_q <= '0;
    end else begin
      ph_q     <= ph_d;
      wr_q     <= wr_d;
      ad_q     <= ad_d;
      rdata_q  <= rdata_d;
      ctrl_q   <= ctrl_d;
      slhi_q   <= slhi_d;
      sllo_q   <= sllo_d;
      irqst_q  <= irqst_d;
      irqmsk_q <= irqmsk_d;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  logic [NAX-1:0] run_d, err_d;
  logic           irq_d;

  always_comb begin
    for (int i = 0; i < NAX; i++) begin
      run_d[i] = (st_d[i] == AX_RUN);
      err_d[i] = (st_d[i] == AX_ERR);
    end
    irq_d = |(irqst_d & irqmsk_d);
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      AXIS_RUN <= '0;
      AXIS_ERR <= '0;
      IRQ      <= 1'b0;
    end else begin
      AXIS_RUN <= run_d;
      AXIS_ERR <= err_d;
      IRQ      <= irq_d;
    end
  end

  // ------------------------------------------------------------
  // Bus response
  // ------------------------------------------------------------
  // Zero wait states: every register answers in its data phase
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  assign HRDATA = rdata_q;

endmodule : aoed_top
`default_nettype wire

// [dv/aoed_properties.sv]
// Port checker for the axis operation error detector
`timescale 1ns/1ns
`default_nettype none
module aoed_properties
  import aoed_pkg::*;
(
  input wire logic                                     CLK,
  input wire logic                                     RSTN,
  input wire logic                                     HSEL,
  input wire logic                                     HREADYOUT,
  input wire logic                                     HRESP,
  input wire aoed_pkg::aoed_axis_in_t [aoed_pkg::NAX-1:0] AXIS_IN,
  input wire logic [aoed_pkg::NAX-1:0]                 AXIS_RUN,
  input wire logic [aoed_pkg::NAX-1:0]                 AXIS_ERR,
  input wire logic                                     IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  aoed_axis_in_t a0;
  logic          idle0;
  assign a0 = AXIS_IN[0];
  assign idle0 = !AXIS_RUN[0] && !AXIS_ERR[0];
  // ------------------------------------------------------------
  // Axis 0 only; the others share the same logic
  // ------------------------------------------------------------
  a_bus_ready: assert property (HREADYOUT) else $error("hreadyout low");
  a_bus_okay: assert property (!HRESP) else $error("hresp not okay");
  a_start_refused: assert property (idle0 && a0.start_req && !a0.servo_lock
    |=> AXIS_ERR[0] && !AXIS_RUN[0]) else $error("start without lock not refused");
  a_start_runs: assert property (idle0 && a0.start_req && a0.servo_lock
    |=> AXIS_RUN[0]) else $error("start with lock did not run");
  a_servo_loss: assert property (AXIS_RUN[0] && a0.busy && !a0.servo_lock |=> AXIS_ERR[0])
    else $error("lock loss in run not flagged");
  a_power_off: assert property (idle0 && $rose(a0.servo_on_req) && !a0.main_pwr
    |=> AXIS_ERR[0]) else $error("servo on without power not flagged");
  a_limit_seen: assert property (AXIS_RUN[0] && a0.busy && a0.lim_plus
    |-> ##[1:6] AXIS_ERR[0]) else $error("plus limit not flagged");
  a_err_sticky: assert property (AXIS_ERR[0] && !HSEL && !$past(HSEL) && !$past(HSEL, 2)
    |=> AXIS_ERR[0]) else $error("error dropped without reset request");
  a_quiet_idle: assert property (idle0 && !a0.start_req && !a0.servo_on_req
    |=> !AXIS_ERR[0]) else $error("error raised while idle");
  c_run: cover property ($rose(AXIS_RUN[0]));
  c_err: cover property ($rose(AXIS_ERR[0]));
  c_irq: cover property ($rose(IRQ));
endmodule : aoed_properties
bind aoed_top aoed_properties chk_u (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .AXIS_IN(AXIS_IN), .AXIS_RUN(AXIS_RUN),
  .AXIS_ERR(AXIS_ERR), .IRQ(IRQ));
`default_nettype wire

// [dv/aoed_amp_model.sv]
// Servo amplifier and limit switch model for one axis
`timescale 1ns/1ns
`default_nettype none
module aoed_amp_model
  import aoed_pkg::*;
(
  input wire logic                    CLK,
  input wire logic                    RSTN,
  input wire aoed_pkg::aoed_axis_in_t CTL,
  output aoed_pkg::aoed_axis_in_t     AX
);
  logic lock_q;
  // Lock lags the request; lost one clock after power drops
  always_ff @(posedge CLK) begin
    lock_q <= RSTN && CTL.servo_on_req && CTL.main_pwr;
  end
  always_comb begin
    AX = CTL;
    AX.servo_lock = lock_q;
  end
endmodule : aoed_amp_model
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the axis operation error detector
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import aoed_pkg::*;
  typedef struct packed { logic [9:0] f; logic [31:0] code; } aoed_row_t;
  logic                    CLK, RSTN, HSEL, HWRITE, HREADYOUT, HRESP, IRQ;
  logic [31:0]             HADDR, HWDATA, HRDATA, r;
  logic [1:0]              HTRANS;
  logic [NAX-1:0]          AXIS_RUN, AXIS_ERR;
  aoed_axis_in_t           ctl, ax0;
  aoed_axis_in_t [NAX-1:0] axis_in;
  int                      fails, checked, cyc;
  aoed_row_t               rows [11];
  assign axis_in = {{((NAX-1)*$bits(aoed_axis_in_t)){1'b0}}, ax0};
  aoed_top dut_u (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .AXIS_IN(axis_in), .AXIS_RUN(AXIS_RUN),
    .AXIS_ERR(AXIS_ERR), .IRQ(IRQ));
  aoed_amp_model amp_u (.CLK(CLK), .RSTN(RSTN), .CTL(ctl), .AX(ax0));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge CLK);
  endtask : wait_n
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1; HTRANS <= 2'h2; HADDR <= {24'h00_0000, a}; HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask : bus
  task automatic fault(input logic [9:0] f);
    @(posedge CLK);
    ctl.lim_plus <= f[0]; ctl.lim_minus <= f[1];
    ctl.position <= f[2] ? 32'h0000_00C8 : f[3] ? 32'hFFFF_FF38 : 32'h0000_0000;
    ctl.spd_ovf_valid <= f[4]; ctl.spd_ovf_kind <= f[6:5]; ctl.op_fault <= f[7];
    ctl.op_abnormal <= f[8]; ctl.amp_warning <= f[9];
  endtask : fault
  task automatic up;
    @(posedge CLK); ctl.servo_on_req <= 1'b1; ctl.main_pwr <= 1'b1;
    wait_n(3);
    @(posedge CLK); ctl.start_req <= 1'b1; ctl.busy <= 1'b1;
    @(posedge CLK); ctl.start_req <= 1'b0;
    wait_n(2);
  endtask : up
  task automatic clear;
    fault(10'h000);
    @(posedge CLK); ctl.busy <= 1'b0;
    @(posedge CLK); ctl.servo_on_req <= 1'b0; ctl.main_pwr <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0000_0103);
    wait_n(2);
    chk("err cleared", AXIS_ERR[0], 1'b0);
  endtask : clear
  // ------------------------------------------------------------
  // Clock, timeout and sequence
  // ------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    RSTN = 1'b0; HSEL = 1'b0; HADDR = '0; HTRANS = '0; HWRITE = 1'b0; HWDATA = '0;
    ctl = '0; fails = 0; checked = 0; cyc = 0;
    rows = '{'{10'h001, EC_LIM_PLUS}, '{10'h002, EC_LIM_MINUS}, '{10'h003, EC_LIM_BOTH},
      '{10'h004, EC_SOFT_PLUS}, '{10'h008, EC_SOFT_MIN}, '{10'h010, EC_SPD_BASE},
      '{10'h030, EC_SPD_BASE + 32'h0000_0001}, '{10'h050, EC_SPD_BASE + 32'h0000_0002},
      '{10'h080, EC_AXIS_OP}, '{10'h100, EC_ABN_END}, '{10'h200, EC_AXIS_OP}};
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    bus(1'b0, OFS_SLHI, '0); chk("slhi", r, RST_SLHI);
    bus(1'b0, OFS_SLLO, '0); chk("sllo", r, RST_SLLO);
    bus(1'b0, OFS_CTRL, '0); chk("ctrl", r, RST_CTRL);
    bus(1'b1, OFS_SLHI, 32'h0000_0064);
    bus(1'b1, OFS_SLLO, 32'hFFFF_FF9C);
    bus(1'b1, OFS_CTRL, 32'h0000_0003);
    bus(1'b1, OFS_IRQMSK, 32'h0000_0001);
    bus(1'b0, 8'h40, '0); chk("unmapped", r, EC_NONE);
    foreach (rows[i]) begin
      up();
      chk("run", AXIS_RUN[0], 1'b1);
      bus(1'b0, OFS_STAT, '0); chk("status run", r, 32'h0000_0001);
      fault(rows[i].f);
      wait_n(8);
      bus(1'b0, OFS_CODE0, '0); chk("code", r, rows[i].code);
      bus(1'b0, OFS_STAT, '0); chk("status err", r, 32'h0000_0003);
      chk("irq", IRQ, 1'b1);
      bus(1'b0, OFS_IRQST, '0); chk("irq status", r, 32'h0000_0001);
      wait_n(2);
      chk("irq after read", IRQ, 1'b0);
      clear();
    end
    @(posedge CLK); ctl.start_req <= 1'b1;
    @(posedge CLK); ctl.start_req <= 1'b0;
    wait_n(2);
    chk("refused run", AXIS_RUN[0], 1'b0);
    bus(1'b0, OFS_CODE0, '0); chk("code", r, EC_NOT_READY);
    clear();
    @(posedge CLK); ctl.servo_on_req <= 1'b1;
    wait_n(2);
    bus(1'b0, OFS_CODE0, '0); chk("code", r, EC_MAIN_OFF);
    clear();
    bus(1'b1, OFS_IRQMSK, 32'h0000_0000);
    up();
    @(posedge CLK); ctl.main_pwr <= 1'b0;
    wait_n(3);
    bus(1'b0, OFS_CODE0, '0); chk("code", r, EC_SVOFF_RUN);
    chk("masked irq", IRQ, 1'b0);
    bus(1'b0, OFS_IRQST, '0); chk("irq status", r, 32'h0000_0001);
    bus(1'b0, OFS_CODE0 + 8'h04, '0); chk("axis 1 code", r, EC_NONE);
    clear();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
